/* core/ocfp_top.sv */
// Output clock, line rate clock and 8k/2k frame generation
`include "ocfp_params.svh"
module ocfp_top
    import ocfp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic primary_tick_i,
    input wire logic secondary_tick_i,
    input wire logic ref_timing_tick_i,
    input wire logic secondary_ref_valid_i,
    input wire logic composite_source_select_i,
    input wire logic auto_squelch_enable_i,
    input wire logic line_rate_out_enable_i,
    input wire logic line_rate_select_secondary_i,
    input wire logic line_rate_select_primary_i,
    input wire logic frame_8k_enable_i,
    input wire logic frame_2k_enable_i,
    input wire logic frame_8k_pulse_mode_i,
    input wire logic frame_2k_pulse_mode_i,
    input wire logic frame_8k_invert_i,
    input wire logic frame_2k_invert_i,
    input wire ocfp_code_t fifth_port_freq_code_i,
    input wire ocfp_code_t sixth_port_freq_code_i,
    input wire logic primary_77m_mode_i,
    input wire logic secondary_gbe_mode_i,
    output logic composite_clock_out_o,
    output logic line_rate_clock_out_o,
    output logic frame_8k_out_o,
    output logic frame_2k_out_o,
    output logic fifth_port_125m_o,
    output logic sixth_port_311m_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    logic src_tick;
    logic squelch;
    logic line_ds1;
    logic line_run;
    logic [9:0] cnt8k_reg;
    logic [1:0] frm2k_reg;
    logic wrap8k;
    logic wrap2k;
    logic [1:0] en_w;
    logic [1:0] pul_w;
    logic [1:0] inv_w;
    logic [1:0] bnd_w;
    logic [1:0] sq_w;
    logic [1:0] run_reg;
    logic [1:0] out_reg;
    ocfp_pulse_e st_reg [2];
    logic fifth_reg;
    logic sixth_reg;

    // Composite and line rate source path
    assign src_tick = composite_source_select_i ? primary_tick_i
                                                : secondary_tick_i;
    assign squelch = !composite_source_select_i && auto_squelch_enable_i
                     && !secondary_ref_valid_i;
    assign line_ds1 = (composite_source_select_i ? line_rate_select_primary_i
                       : line_rate_select_secondary_i)
                      == `OCFP_RATE_SEL_DS1;
    assign line_run = line_rate_out_enable_i && !squelch;

    ocfp_comp_div u_comp_div (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .run_i(!squelch),
        .tick_i(src_tick),
        .clk_o(composite_clock_out_o)
    );

    ocfp_dfs u_dfs (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .run_i(line_run),
        .tick_i(src_tick),
        .ds1_sel_i(line_ds1),
        .clk_o(line_rate_clock_out_o)
    );

    // Shared frame counter on the primary tick keeps 8k and 2k aligned
    assign wrap8k = primary_tick_i
                    && cnt8k_reg == 10'(`OCFP_FRAME_8K_TICKS - 1);
    assign wrap2k = wrap8k && frm2k_reg == 2'(`OCFP_FRAMES_PER_2K - 1);

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cnt8k_reg <= `OCFP_RST_CNT;
        end else if (wrap8k) begin
            cnt8k_reg <= `OCFP_RST_CNT;
        end else if (primary_tick_i) begin
            cnt8k_reg <= cnt8k_reg + 10'h001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            frm2k_reg <= 2'h0;
        end else if (wrap8k) begin
            frm2k_reg <= frm2k_reg + 2'h1;
        end
    end

    assign en_w = {frame_2k_enable_i, frame_8k_enable_i};
    assign pul_w = {frame_2k_pulse_mode_i, frame_8k_pulse_mode_i};
    assign inv_w = {frame_2k_invert_i, frame_8k_invert_i};
    assign bnd_w = {wrap2k, wrap8k};
    assign sq_w[0] = cnt8k_reg < 10'(`OCFP_FRAME_8K_HALF);
    assign sq_w[1] = frm2k_reg < 2'(`OCFP_FRAMES_2K_HALF);

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_frame
            // Held off until a boundary so a restart never gives a runt
            always_ff @(posedge ref_clk_i) begin
                if (!nrst_i || !en_w[ch]) begin
                    run_reg[ch] <= 1'b0;
                end else if (bnd_w[ch]) begin
                    run_reg[ch] <= 1'b1;
                end
            end

            // Pulse waits for the next reference edge after the boundary
            always_ff @(posedge ref_clk_i) begin
                if (!nrst_i) begin
                    st_reg[ch] <= FP_IDLE;
                end else begin
                    unique case (st_reg[ch])
                        FP_IDLE: begin
                            if (en_w[ch] && pul_w[ch] && bnd_w[ch]) begin
                                st_reg[ch] <= FP_ARM;
                            end
                        end
                        FP_ARM: begin
                            if (!en_w[ch] || !pul_w[ch]) begin
                                st_reg[ch] <= FP_IDLE;
                            end else if (ref_timing_tick_i) begin
                                st_reg[ch] <= FP_LOW;
                            end
                        end
                        FP_LOW: begin
                            if (!en_w[ch] || ref_timing_tick_i) begin
                                st_reg[ch] <= FP_IDLE;
                            end
                        end
                        default: begin
                            st_reg[ch] <= FP_IDLE;
                        end
                    endcase
                end
            end

            always_ff @(posedge ref_clk_i) begin
                if (!nrst_i || !en_w[ch] || !run_reg[ch]) begin
                    out_reg[ch] <= 1'b0;
                end else if (pul_w[ch]) begin
                    out_reg[ch] <= (st_reg[ch] != FP_LOW)
                                   ^ inv_w[ch];
                end else begin
                    out_reg[ch] <= sq_w[ch] ^ inv_w[ch];
                end
            end

            sequence s_arm_edge;
                st_reg[ch] == FP_ARM && en_w[ch] && pul_w[ch]
                    && ref_timing_tick_i;
            endsequence

            sequence s_low_hold;
                st_reg[ch] == FP_LOW && en_w[ch] && !ref_timing_tick_i;
            endsequence

            a_pulse_start_edge:
                assert property (s_arm_edge |=> st_reg[ch] == FP_LOW
                                 ##1 (out_reg[ch] == inv_w[ch]
                                      || !run_reg[ch]))
                else $error("frame pulse did not start on reference edge");

            a_pulse_one_cycle:
                assert property (st_reg[ch] == FP_LOW && ref_timing_tick_i
                                 |=> st_reg[ch] == FP_IDLE)
                else $error("frame pulse outlived one reference cycle");

            a_pulse_low_hold:
                assert property (s_low_hold |=> st_reg[ch] == FP_LOW)
                else $error("frame pulse ended before reference edge");

            a_frame_disabled_low:
                assert property (!en_w[ch] |=> !out_reg[ch])
                else $error("disabled frame output not held low");

            a_square_half:
                assert property (en_w[ch] && run_reg[ch] && !pul_w[ch]
                                 && !inv_w[ch] && !sq_w[ch]
                                 |=> !out_reg[ch])
                else $error("square frame clock high in its low half");
        end
    endgenerate

    assign frame_8k_out_o = out_reg[0];
    assign frame_2k_out_o = out_reg[1];

    // High-rate port qualifiers
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            sixth_reg <= 1'b0;
        end else begin
            sixth_reg <= sixth_port_freq_code_i == `OCFP_CODE_311M
                         && primary_77m_mode_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            fifth_reg <= 1'b0;
        end else begin
            fifth_reg <= fifth_port_freq_code_i == `OCFP_CODE_125M
                         && secondary_gbe_mode_i;
        end
    end

    assign sixth_port_311m_o = sixth_reg;
    assign fifth_port_125m_o = fifth_reg;

    a_squelch_both:
        assert property (squelch |=> !composite_clock_out_o
                         && !line_rate_clock_out_o)
        else $error("squelched outputs still active");

    a_line_disabled:
        assert property (!line_rate_out_enable_i |=> !line_rate_clock_out_o)
        else $error("line rate output active while disabled");

    a_port_311m:
        assert property (1'b1 |=> sixth_port_311m_o
                         == $past(sixth_port_freq_code_i
                         == `OCFP_CODE_311M && primary_77m_mode_i))
        else $error("sixth port 311 MHz qualifier wrong");

    a_port_125m:
        assert property (fifth_port_freq_code_i == `OCFP_CODE_125M
                         && secondary_gbe_mode_i |=> fifth_port_125m_o)
        else $error("fifth port 125 MHz qualifier missing");

    a_frame_wrap:
        assert property (wrap8k |=> cnt8k_reg == `OCFP_RST_CNT)
        else $error("8k frame counter did not wrap");
endmodule // ocfp_top

/* core/ocfp_params.svh */
// Timing counts, encodings and codes for the output clock and frame block
`ifndef OCFP_PARAMS_SVH
`define OCFP_PARAMS_SVH

// Nominal rate of the synthesis input tick from either path
`define OCFP_SRC_TICK_HZ 8192000
`define OCFP_SRC_TICK_KHZ 8192

// Composite clock: 64 kHz by direct division
`define OCFP_COMP_HZ 64000
`define OCFP_COMP_TICKS (`OCFP_SRC_TICK_HZ / `OCFP_COMP_HZ)
`define OCFP_COMP_HALF (`OCFP_COMP_TICKS / 2)

// 8 kHz frame of 125000 ns, 2 kHz frame of 500000 ns
`define OCFP_FRAME_8K_NS 125000
`define OCFP_FRAME_2K_NS 500000
`define OCFP_FRAME_8K_TICKS \
    (`OCFP_SRC_TICK_KHZ * `OCFP_FRAME_8K_NS / 1000000)
`define OCFP_FRAME_8K_HALF (`OCFP_FRAME_8K_TICKS / 2)
`define OCFP_FRAMES_PER_2K (`OCFP_FRAME_2K_NS / `OCFP_FRAME_8K_NS)
`define OCFP_FRAMES_2K_HALF (`OCFP_FRAMES_PER_2K / 2)

// Phase increments per source tick, 24-bit accumulator
`define OCFP_DFS_INC_DS1 24'h304000
`define OCFP_DFS_INC_E1 24'h400000
// Rate select level that picks the DS1 rate
`define OCFP_RATE_SEL_DS1 1'b1

// Output frequency codes of the two high-rate ports
`define OCFP_CODE_311M 4'h5
`define OCFP_CODE_125M 4'hb

// Reset values
`define OCFP_RST_CNT 10'h000
`define OCFP_RST_ACC 24'h000000

`endif

/* core/ocfp_pkg.sv */
// Types shared by the output clock and frame block
package ocfp_pkg;
    typedef enum logic [2:0] {
        FP_IDLE = 3'b001,
        FP_ARM = 3'b010,
        FP_LOW = 3'b100
    } ocfp_pulse_e;
    typedef logic [3:0] ocfp_code_t;
endpackage

/* core/ocfp_comp_div.sv */
// Composite clock divider: square 64 kHz by integer division of the tick
`include "ocfp_params.svh"
module ocfp_comp_div
    import ocfp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic tick_i,
    output logic clk_o
);
    logic [6:0] cnt_reg;
    logic clk_reg;

    // Cleared while stopped so a restart begins a whole period
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || !run_i) begin
            cnt_reg <= 7'h00;
        end else if (tick_i) begin
            if (cnt_reg == 7'(`OCFP_COMP_TICKS - 1)) begin
                cnt_reg <= 7'h00;
            end else begin
                cnt_reg <= cnt_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || !run_i) begin
            clk_reg <= 1'b0;
        end else begin
            clk_reg <= (cnt_reg < 7'(`OCFP_COMP_HALF));
        end
    end

    assign clk_o = clk_reg;
endmodule // ocfp_comp_div

/* core/ocfp_dfs.sv */
// Line rate synthesiser: phase accumulator stepping on the source tick
`include "ocfp_params.svh"
module ocfp_dfs
    import ocfp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic ds1_sel_i,
    output logic clk_o
);
    logic [23:0] acc_reg;
    logic [23:0] inc;
    logic clk_reg;

    assign inc = ds1_sel_i ? `OCFP_DFS_INC_DS1 : `OCFP_DFS_INC_E1;

    // Fractional step, so edges carry up to one tick of jitter
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || !run_i) begin
            acc_reg <= `OCFP_RST_ACC;
        end else if (tick_i) begin
            acc_reg <= acc_reg + inc;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || !run_i) begin
            clk_reg <= 1'b0;
        end else begin
            clk_reg <= acc_reg[23];
        end
    end

    assign clk_o = clk_reg;
endmodule // ocfp_dfs

/* test/ocfp_tick_source.sv */
// Tick source model for the two synthesis paths and the reference clock
module ocfp_tick_source #(
    parameter int REF_DIV = 4
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [31:0] pri_step_i,
    input wire logic [31:0] sec_step_i,
    output logic primary_tick_o,
    output logic secondary_tick_o,
    output logic ref_timing_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Phase accumulators against the 20 MHz bench clock; rates are per run
    localparam int BASE = 32'h1312d00;
    int pri_acc = 0;
    // Secondary starts out of phase with the primary accumulator
    int sec_acc = 32'h6f0000;
    int ref_cnt = 0;
    initial begin
        primary_tick_o = 1'b0;
        secondary_tick_o = 1'b0;
        ref_timing_tick_o = 1'b0;
    end
    always @(posedge ref_clk_i) begin
        pri_acc <= (pri_acc + pri_step_i) % BASE;
        sec_acc <= (sec_acc + sec_step_i) % BASE;
        primary_tick_o <= nrst_i && (pri_acc + pri_step_i >= BASE);
        secondary_tick_o <= nrst_i && (sec_acc + sec_step_i >= BASE);
        ref_cnt <= (ref_cnt + 1) % REF_DIV;
        // 5 MHz from the 20 MHz bench clock divided by REF_DIV, well above the pulse-mode floor
        ref_timing_tick_o <= nrst_i && (ref_cnt == 0);
    end
endmodule // ocfp_tick_source

/* test/test_output_clock_frame_pulse_config.sv */
// Self-checking bench for the output clock and frame block
`include "ocfp_params.svh"
module test_output_clock_frame_pulse_config;
    import ocfp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REF_DIV = 4;
    localparam int LIM = 30000;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [31:0] pri_step = 32'h7d0000;
    logic [31:0] sec_step = 32'h2dc6c0;
    logic pt, st, rt;
    logic sel = 1'b0, asq = 1'b0, valid = 1'b1, lr_en = 1'b1;
    logic lr_sec = 1'b0, lr_pri = 1'b0, m77 = 1'b0, gbe = 1'b0;
    logic e8 = 1'b0, e2 = 1'b0, p8 = 1'b0, p2 = 1'b0, i8 = 1'b0, i2 = 1'b0;
    ocfp_code_t c5 = 4'h0, c6 = 4'h0;
    logic comp, line, f8, f2, q125, q311;
    int err_total = 0;
    int total_checks = 0;
    int seed = 32'h4c54059f;

    always #25 ref_clk_i = ~ref_clk_i;

    ocfp_tick_source #(.REF_DIV(REF_DIV)) u_src (.ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i), .pri_step_i(pri_step), .sec_step_i(sec_step),
        .primary_tick_o(pt), .secondary_tick_o(st), .ref_timing_tick_o(rt));

    ocfp_top u_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .primary_tick_i(pt), .secondary_tick_i(st), .ref_timing_tick_i(rt),
        .secondary_ref_valid_i(valid), .composite_source_select_i(sel),
        .auto_squelch_enable_i(asq), .line_rate_out_enable_i(lr_en),
        .line_rate_select_secondary_i(lr_sec),
        .line_rate_select_primary_i(lr_pri), .frame_8k_enable_i(e8),
        .frame_2k_enable_i(e2), .frame_8k_pulse_mode_i(p8),
        .frame_2k_pulse_mode_i(p2), .frame_8k_invert_i(i8),
        .frame_2k_invert_i(i2), .fifth_port_freq_code_i(c5),
        .sixth_port_freq_code_i(c6), .primary_77m_mode_i(m77),
        .secondary_gbe_mode_i(gbe), .composite_clock_out_o(comp),
        .line_rate_clock_out_o(line), .frame_8k_out_o(f8),
        .frame_2k_out_o(f2), .fifth_port_125m_o(q125),
        .sixth_port_311m_o(q311));

    function automatic logic lvl(input int k, input logic inv);
        case (k)
            0: lvl = comp;
            1: lvl = line;
            2: lvl = f8 ^ inv;
            default: lvl = f2 ^ inv;
        endcase
    endfunction

    // Source 0 is the secondary path, 1 the primary, as the select encodes
    function automatic int tk(input int src);
        return (src == 0) ? int'(st === 1'b1) : int'(pt === 1'b1);
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    // Alignment to the reference tick moves edges by a few source ticks
    task automatic near(input string nm, input int exp, input int got,
                        input int tol);
        chk(nm, exp, ((got - exp) <= tol && (exp - got) <= tol) ? exp : got);
    endtask

    // Ticks while high, ticks and cycles while low, over one full period
    task automatic measure(input int k, input int src, input logic inv,
                           output int ht, output int lt, output int lc);
        int n;
        int pv;
        ht = 0;
        lt = 0;
        lc = 0;
        n = 0;
        pv = 0;
        // Output lags its counter by one cycle, so credit the previous tick
        while (n < LIM && lvl(k, inv) !== 1'b0) begin
            pv = tk(src);
            @(negedge ref_clk_i);
            n++;
        end
        while (n < LIM && lvl(k, inv) === 1'b0) begin
            pv = tk(src);
            @(negedge ref_clk_i);
            n++;
        end
        while (n < LIM && lvl(k, inv) === 1'b1) begin
            ht += pv;
            pv = tk(src);
            @(negedge ref_clk_i);
            n++;
        end
        while (n < LIM && lvl(k, inv) === 1'b0) begin
            lt += pv;
            lc++;
            pv = tk(src);
            @(negedge ref_clk_i);
            n++;
        end
        if (n >= LIM) begin
            err_total++;
            $display("CHECK FAILED period of output %0d expected edges", k);
            summarize();
        end
    endtask

    // Rising edges of the line rate output over 2048 source ticks
    task automatic rate(input int src, output int e);
        int t;
        int c;
        logic p;
        t = 0;
        c = 0;
        e = 0;
        p = line;
        while (t < 2048 && c < LIM) begin
            @(negedge ref_clk_i);
            c++;
            t += tk(src);
            if (line === 1'b1 && p === 1'b0) e++;
            p = line;
        end
        if (c >= LIM) begin
            err_total++;
            $display("CHECK FAILED source ticks expected 2048 seen %0d", t);
            summarize();
        end
    endtask

    initial begin
        int ht, lt, lc, e, k, m, n;
        logic inv;
        longint inc;
        repeat (2) @(negedge ref_clk_i);
        chk("outputs in reset", 32'h0, {comp, line, f8, f2, q125, q311});
        @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        for (k = 0; k < 2; k++) begin
            @(posedge ref_clk_i);
            sel <= k[0];
            measure(0, k, 1'b0, ht, lt, lc);
            chk("composite high ticks", `OCFP_COMP_HALF, ht);
            chk("composite low ticks", `OCFP_COMP_HALF, lt);
        end
        @(posedge ref_clk_i);
        sel <= 1'b0;
        asq <= 1'b1;
        valid <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        n = 0;
        repeat (900) begin
            @(negedge ref_clk_i);
            n += int'(comp === 1'b1 || line === 1'b1);
        end
        chk("squelched high cycles", 0, n);
        @(posedge ref_clk_i);
        sel <= 1'b1;
        measure(0, 1, 1'b0, ht, lt, lc);
        chk("unsquelched primary ticks", `OCFP_COMP_TICKS, ht + lt);
        @(posedge ref_clk_i);
        valid <= 1'b1;
        sec_step <= 32'h7d0000;
        for (k = 0; k < 4; k++) begin
            @(posedge ref_clk_i);
            sel <= k[1];
            lr_sec <= k[1] ? ~k[0] : k[0];
            lr_pri <= k[1] ? k[0] : ~k[0];
            inc = k[0] ? `OCFP_DFS_INC_DS1 : `OCFP_DFS_INC_E1;
            repeat (4) @(negedge ref_clk_i);
            rate(k / 2, e);
            near("line rate edges", int'((inc * 2048) >> 24), e, 1);
        end
        @(posedge ref_clk_i);
        lr_en <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        rate(1, e);
        chk("disabled line edges", 0, e);
        chk("disabled line level", 1'b0, line);
        pri_step <= 32'hf42400;
        sec_step <= 32'h2dc6c0;
        for (k = 2; k < 4; k++) begin
            for (m = 0; m < 2; m++) begin
                inv = $random(seed);
                n = `OCFP_FRAME_8K_TICKS * ((k == 2) ? 1 : 4);
                @(posedge ref_clk_i);
                e8 <= (k == 2);
                e2 <= (k == 3);
                p8 <= m[0];
                p2 <= m[0];
                i8 <= inv;
                i2 <= inv;
                // Let the output reach its first boundary before timing it
                repeat ((k == 2) ? 1300 : 5200) @(negedge ref_clk_i);
                measure(k, 1, inv, ht, lt, lc);
                if (m == 0) begin
                    chk("frame clock high ticks", n / 2, ht);
                    chk("frame clock low ticks", n / 2, lt);
                end else begin
                    chk("frame pulse cycles", REF_DIV, lc);
                    near("frame pulse spacing", n, ht + lt, 4);
                end
                chk("idle frame output", 1'b0, (k == 2) ? f2 : f8);
            end
        end
        @(posedge ref_clk_i);
        e2 <= 1'b0;
        i2 <= 1'b1;
        repeat (3) @(negedge ref_clk_i);
        n = 0;
        repeat (6000) begin
            @(negedge ref_clk_i);
            n += int'(f2 !== 1'b0);
        end
        chk("disabled 2k nonzero cycles", 0, n);
        for (k = 0; k < 48; k++) begin
            @(posedge ref_clk_i);
            c5 <= (k % 3 == 0) ? 4'hb : 4'($random(seed));
            c6 <= (k % 3 == 1) ? 4'h5 : 4'($random(seed));
            m77 <= $random(seed);
            gbe <= $random(seed);
            repeat (2) @(negedge ref_clk_i);
            chk("sixth port qualifier", c6 == 4'h5 && m77, q311);
            chk("fifth port qualifier", c5 == 4'hb && gbe, q125);
        end
        summarize();
    end
endmodule // test_output_clock_frame_pulse_config
